// ==== shared/bsc_pkg.sv ====
// constants for the bit-skip and call decode block
package bsc_pkg;
    // instruction word and program counter widths
    localparam int IW = 12;
    localparam int PW = 11;
    // opcode field and the two patterns this block acts on
    localparam int          OP_HI      = 11;
    localparam int          OP_LO      = 8;
    localparam logic [3:0]  OP_SKIPSET = 4'h7;
    localparam logic [3:0]  OP_CALL    = 4'h9;
    // operand field positions
    localparam int BIT_HI  = 7;
    localparam int BIT_LO  = 5;
    localparam int REG_HI  = 4;
    localparam int REG_LO  = 0;
    localparam int LIT_HI  = 7;
    localparam int LIT_LO  = 0;
    // status bits that select the program memory page
    localparam int PAGE_HI = 6;
    localparam int PAGE_LO = 5;
    // word executed in place of a flushed prefetch
    localparam logic [IW-1:0] NOP_WORD = 12'h000;
    // reset values
    localparam logic [IW-1:0] RST_WORD = 12'h000;
    localparam logic [PW-1:0] RST_PC   = 11'h000;
    localparam logic [4:0]    RST_REG  = 5'h00;
    // execution states
    typedef enum logic [0:0] {ST_RUN, ST_FLUSH} bsc_state_e;
endpackage

// ==== shared/bsc_dec_if.sv ====
// decoded fields passed from the decoder to the executing logic
`timescale 1ns/10ps
`default_nettype none
interface bsc_dec_if;
    logic [11:0] instr;
    logic        is_skip_set;
    logic        is_call;
    logic [2:0]  bit_idx;
    logic [4:0]  reg_addr;
    logic [7:0]  literal;
    modport dec (input instr, output is_skip_set, is_call, bit_idx,
                 reg_addr, literal);
    modport use_side (output instr, input is_skip_set, is_call, bit_idx,
                      reg_addr, literal);
endinterface
`default_nettype wire

// ==== logic/bsc_decode.sv ====
// field decoder for the bit-skip and call instructions
`timescale 1ns/10ps
`default_nettype none
module bsc_decode (
    bsc_dec_if.dec d
);
    import bsc_pkg::*;

    // opcode match used for both patterns
    function automatic logic op_is(input logic [IW-1:0] w,
                                   input logic [3:0] op);
        op_is = (w[OP_HI:OP_LO] == op);
    endfunction

    // pattern match and operand extraction
    assign d.is_skip_set = op_is(d.instr, OP_SKIPSET);
    assign d.is_call     = op_is(d.instr, OP_CALL);
    assign d.bit_idx     = d.instr[BIT_HI:BIT_LO];
    assign d.reg_addr    = d.instr[REG_HI:REG_LO];
    assign d.literal     = d.instr[LIT_HI:LIT_LO];
endmodule
`default_nettype wire

// ==== logic/bsc_core.sv ====
// execute logic for bit-test-skip-if-set and subroutine call
//
// How it works
// - bit-test pattern decodes bit index and register; skip when bit is one
// - taken skip replaces the prefetched word by a no-op: two cycles
// - call pushes its own address plus one onto the return stack
// - call loads the eight-bit literal into program counter bits 7:0
// - call copies status bits 6:5 into program counter bits 10:9
// - call clears program counter bit 8
// - call takes two cycles, flushing the prefetched sequential word
`timescale 1ns/10ps
`default_nettype none
module bsc_core (
    input  wire logic                   REF_CLK,
    input  wire logic                   RESET,
    input  wire logic                   CYCLE_EN,
    input  wire logic [bsc_pkg::IW-1:0] INSTR_WORD,
    input  wire logic [bsc_pkg::PW-1:0] INSTR_PC,
    input  wire logic [7:0]             STATUS_IN,
    input  wire logic [7:0]             RF_DATA,
    output logic      [4:0]             RF_ADDR,
    output logic      [bsc_pkg::IW-1:0] EXEC_WORD,
    output logic                        SKIP_TAKEN,
    output logic                        PUSH_STB,
    output logic      [bsc_pkg::PW-1:0] RETURN_STACK_TOP,
    output logic                        PC_LOAD_STB,
    output logic      [bsc_pkg::PW-1:0] PC_LOAD_VALUE,
    output logic                        STATUS_WE
);
    import bsc_pkg::*;

    // execution state, executing word and its operand address
    bsc_state_e      state_q;
    bsc_state_e      state_d;
    logic [IW-1:0]   ir_q;
    logic [IW-1:0]   ir_d;
    logic [PW-1:0]   pc_q;
    logic [4:0]      rf_addr_q;
    logic [4:0]      rf_addr_d;
    // strobes and the values they qualify
    logic            skip_q;
    logic            skip_d;
    logic            push_q;
    logic            push_d;
    logic            load_q;
    logic            load_d;
    logic [PW-1:0]   tos_q;
    logic [PW-1:0]   tos_d;
    logic [PW-1:0]   load_val_q;
    logic [PW-1:0]   load_val_d;
    logic            status_we_q;

    // address of the following word, wrapping within the pc width
    function automatic logic [PW-1:0] next_addr(input logic [PW-1:0] pc);
        next_addr = PW'(pc + 11'h001);
    endfunction

    // call destination: page from status, bit 8 clear, literal below
    function automatic logic [PW-1:0] call_target(input logic [7:0] status,
                                                  input logic [7:0] lit);
        call_target = {status[PAGE_HI:PAGE_LO],
                       1'b0,
                       lit};
    endfunction

    // decoded fields of the executing word
    bsc_dec_if dif ();

    // decoder looks at the word now executing
    assign dif.instr = ir_q;

    // field decoder
    bsc_decode bsc_decode_i (
        .d (dif)
    );

    // outcome of the executing word; a flush cycle holds a no-op
    wire          in_run    = (state_q == ST_RUN);
    wire          bit_set   = RF_DATA[dif.bit_idx];
    wire          skip_now  = in_run && dif.is_skip_set && bit_set;
    wire          call_now  = in_run && dif.is_call;
    wire          flush_now = skip_now || call_now;
    wire          skip_fire = CYCLE_EN && skip_now;
    wire          call_fire = CYCLE_EN && call_now;
    wire [PW-1:0] ret_addr  = next_addr(pc_q);
    wire [PW-1:0] call_tgt  = call_target(STATUS_IN, dif.literal);

    // state: one flush cycle follows a taken skip or a call
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_RUN: begin
                if (flush_now) begin
                    state_d = ST_FLUSH;
                end
            end
            ST_FLUSH: begin
                state_d = ST_RUN;
            end
            default: begin
                state_d = ST_RUN;
            end
        endcase
    end

    // next values: prefetch or a no-op, strobes, held call values
    assign ir_d       = flush_now ? NOP_WORD : INSTR_WORD;
    assign rf_addr_d  = ir_d[REG_HI:REG_LO];
    assign skip_d     = skip_fire;
    assign push_d     = call_fire;
    assign load_d     = call_fire;
    assign tos_d      = call_fire ? ret_addr : tos_q;
    assign load_val_d = call_fire ? call_tgt : load_val_q;

    // execution state, advanced once per instruction cycle
    always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            state_q <= ST_RUN;
        end else if (CYCLE_EN) begin
            state_q <= state_d;
        end
    end

    // executing word
    always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            ir_q <= RST_WORD;
        end else if (CYCLE_EN) begin
            ir_q <= ir_d;
        end
    end

    // address of the executing word
    always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            pc_q <= RST_PC;
        end else if (CYCLE_EN) begin
            pc_q <= INSTR_PC;
        end
    end

    // register file address of the executing word
    always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            rf_addr_q <= RST_REG;
        end else if (CYCLE_EN) begin
            rf_addr_q <= rf_addr_d;
        end
    end

    // skip strobe, one clock wide, starting at the resolving cycle end
    always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            skip_q <= 1'b0;
        end else begin
            skip_q <= skip_d;
        end
    end

    // push strobe for the return stack
    always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            push_q <= 1'b0;
        end else begin
            push_q <= push_d;
        end
    end

    // program counter load strobe
    always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            load_q <= 1'b0;
        end else begin
            load_q <= load_d;
        end
    end

    // return address, held until the next call
    always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            tos_q <= RST_PC;
        end else begin
            tos_q <= tos_d;
        end
    end

    // call target, held until the next call
    always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            load_val_q <= RST_PC;
        end else begin
            load_val_q <= load_val_d;
        end
    end

    // status is never written by these instructions
    always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            status_we_q <= 1'b0;
        end else begin
            status_we_q <= 1'b0;
        end
    end

    // outputs straight from their flip-flops
    assign RF_ADDR          = rf_addr_q;
    assign EXEC_WORD        = ir_q;
    assign SKIP_TAKEN       = skip_q;
    assign PUSH_STB         = push_q;
    assign RETURN_STACK_TOP = tos_q;
    assign PC_LOAD_STB      = load_q;
    assign PC_LOAD_VALUE    = load_val_q;
    assign STATUS_WE        = status_we_q;
endmodule
`default_nettype wire

// ==== verification/bsc_core_asserts.sv ====
// assertions for the skip and call execute block
`timescale 1ns/10ps
`default_nettype none
module bsc_core_asserts (
    input wire logic        REF_CLK,
    input wire logic        RESET,
    input wire logic        CYCLE_EN,
    input wire logic [11:0] INSTR_WORD,
    input wire logic [10:0] INSTR_PC,
    input wire logic [7:0]  STATUS_IN,
    input wire logic [7:0]  RF_DATA,
    input wire logic [4:0]  RF_ADDR,
    input wire logic [11:0] EXEC_WORD,
    input wire logic        SKIP_TAKEN,
    input wire logic        PUSH_STB,
    input wire logic [10:0] RETURN_STACK_TOP,
    input wire logic        PC_LOAD_STB,
    input wire logic [10:0] PC_LOAD_VALUE,
    input wire logic        STATUS_WE
);
    logic [10:0] pc_q; // address of the executing word
    // resolving bit test and call
    wire logic bt = CYCLE_EN && EXEC_WORD[11:8] == 4'h7;
    wire logic hit = RF_DATA[EXEC_WORD[7:5]];
    wire logic rc = CYCLE_EN && EXEC_WORD[11:8] == 4'h9;
    wire logic fl = (bt && hit) || rc;
    // follow the address of each taken word
    always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            pc_q <= 11'h000;
        end else if (CYCLE_EN) begin
            pc_q <= INSTR_PC;
        end
    end
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RESET);
    // no-op in place, then strobes drop
    sequence s_nop;
        EXEC_WORD == 12'h000;
    endsequence
    sequence s_drop;
        !PUSH_STB && !PC_LOAD_STB;
    endsequence
    sequence s_flush;
        s_nop ##1 s_drop;
    endsequence
    property p_skip;
        bt && hit |=> SKIP_TAKEN && EXEC_WORD == 12'h000;
    endproperty
    a_skip: assert property (p_skip)
        else $error("skip missed");
    property p_keep;
        bt && !hit |=> !SKIP_TAKEN && EXEC_WORD == $past(INSTR_WORD);
    endproperty
    a_keep: assert property (p_keep)
        else $error("bad skip");
    property p_noskip;
        !(bt && hit) |=> !SKIP_TAKEN;
    endproperty
    a_noskip: assert property (p_noskip)
        else $error("spurious skip");
    property p_addr;
        CYCLE_EN && !fl |=> RF_ADDR == $past(INSTR_WORD[4:0]);
    endproperty
    a_addr: assert property (p_addr)
        else $error("bad register address");
    property p_push;
        rc |=> PUSH_STB && RETURN_STACK_TOP == $past(pc_q) + 11'h1;
    endproperty
    a_push: assert property (p_push)
        else $error("bad push");
    property p_quiet;
        !rc |=> s_drop;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("spurious call strobe");
    property p_lit;
        rc |=> PC_LOAD_STB && PC_LOAD_VALUE[7:0] == $past(EXEC_WORD[7:0]);
    endproperty
    a_lit: assert property (p_lit)
        else $error("bad literal");
    property p_page;
        rc |=> PC_LOAD_VALUE[10:9] == $past(STATUS_IN[6:5]);
    endproperty
    a_page: assert property (p_page)
        else $error("bad page");
    property p_bit8;
        PC_LOAD_STB |-> !PC_LOAD_VALUE[8];
    endproperty
    a_bit8: assert property (p_bit8)
        else $error("pc bit 8 set");
    property p_flush;
        rc |=> s_flush;
    endproperty
    a_flush: assert property (p_flush)
        else $error("no flush");
    property p_stat;
        !STATUS_WE;
    endproperty
    a_stat: assert property (p_stat)
        else $error("status written");
endmodule
bind bsc_core bsc_core_asserts bsc_core_asserts_i (.REF_CLK, .RESET,
    .CYCLE_EN, .INSTR_WORD, .INSTR_PC, .STATUS_IN, .RF_DATA, .RF_ADDR,
    .EXEC_WORD, .SKIP_TAKEN, .PUSH_STB, .RETURN_STACK_TOP, .PC_LOAD_STB,
    .PC_LOAD_VALUE, .STATUS_WE);
`default_nettype wire

// ==== verification/bsc_core_tb.sv ====
// self-checking bench for the skip and call execute block
`timescale 1ns/10ps
`default_nettype none
module bsc_core_tb;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        en = 1'b0;
    logic [11:0] iw = 12'h000;
    logic [10:0] ipc = 11'h000;
    logic [7:0]  st = 8'h00;
    logic [7:0]  rf = 8'h00;
    logic [4:0]  ra;
    logic [11:0] xw;
    logic        skp, psh, pld, swe;
    logic [10:0] return_stack_top, pcv;
    int          err_count = 0;
    int          comparisons = 0;
    bsc_core bsc_core_i (.REF_CLK(clk), .RESET(rst), .CYCLE_EN(en),
        .INSTR_WORD(iw), .INSTR_PC(ipc), .STATUS_IN(st), .RF_DATA(rf),
        .RF_ADDR(ra), .EXEC_WORD(xw), .SKIP_TAKEN(skp), .PUSH_STB(psh),
        .RETURN_STACK_TOP(return_stack_top), .PC_LOAD_STB(pld), .PC_LOAD_VALUE(pcv),
        .STATUS_WE(swe));
    // 100 MHz clock
    always #5 clk = ~clk;
    // compare and count
    task automatic chk(string n, logic [11:0] s, logic [11:0] e);
        comparisons++;
        if (s !== e) begin
            err_count++;
            $display("[FAIL] %s exp %h seen %h", n, e, s);
        end
    endtask
    // one instruction cycle; outputs settled on return
    task automatic step(logic [11:0] w, logic [10:0] p, logic [7:0] r,
                        logic [7:0] s);
        @(posedge clk);
        en <= 1'b1;
        iw <= w;
        ipc <= p;
        rf <= r;
        st <= s;
        @(posedge clk);
        en <= 1'b0;
        #1;
    endtask
    // bit test taken then untaken
    task automatic t_skip();
        step(12'h7a3, 11'h010, 8'h00, 8'h00);
        chk("rf_addr", 12'(ra), 12'h003);
        step(12'h123, 11'h011, 8'h20, 8'h00);
        chk("skip", 12'(skp), 12'h001);
        chk("exec", xw, 12'h000);
        step(12'h7a3, 11'h012, 8'h00, 8'h00);
        chk("skip", 12'(skp), 12'h000);
        step(12'h456, 11'h013, 8'hdf, 8'h00);
        chk("skip", 12'(skp), 12'h000);
        chk("exec", xw, 12'h456);
        $display("skip test done");
    endtask
    // call on every page with a fresh literal; first return address wraps
    task automatic t_call();
        logic [10:0] p;
        logic [7:0]  k;
        for (int i = 0; i < 4; i++) begin
            p = 11'h7ff - 11'(i * 11'h155);
            k = 8'h5a ^ 8'(i * 8'h33);
            step({4'h9, k}, p, 8'h00, 8'h00);
            step(12'h5aa, 11'h000, 8'h00, {1'b1, i[1:0], 5'h1f});
            chk("strobes", 12'({psh, pld}), 12'h003);
            chk("tos", 12'(return_stack_top), 12'(11'(p + 11'h001)));
            chk("lit", 12'(pcv[7:0]), 12'(k));
            chk("page", 12'(pcv[10:9]), 12'(i[1:0]));
            chk("bit8", 12'(pcv[8]), 12'h000);
            chk("exec", xw, 12'h000);
            chk("swe", 12'(swe), 12'h000);
            @(posedge clk) #1;
            chk("strobes", 12'({psh, pld}), 12'h000);
        end
        $display("call test done");
    endtask
    // counts and verdict
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // reset then scenarios
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_skip();
        t_call();
        final_report();
    end
    // watchdog
    initial begin
        #20000;
        err_count++;
        final_report();
    end
endmodule
`default_nettype wire
